/* File: verif/srcl_rom_model.sv */
`timescale 1ns/10ps
module srcl_rom_model #(parameter int ABITS = 6) (
   // Serial pins
   input wire logic sclk,
   input wire logic cs,
   input wire logic din,
   output logic dout
);
   logic [15:0] sh = 16'h0000;
   logic [15:0] word = 16'h0000;
   logic [15:0] ck = 16'hAAAA;
   int n = 0;
   initial dout = 1'b0;
   always @(posedge sclk or negedge cs) begin
      if (!cs) begin
         n = 0;
         dout <= 1'b0;
      end else begin
         sh = {sh[14:0], din};
         n = n + 1;
         if (n == 3 + ABITS) begin
            // word Dh holds the matching checksum
            if (sh[ABITS-1:0] == 4'hD) word = ck;
            else word = 16'hA500 ^ sh;
            if (sh[ABITS-1:0] < 4'hD) ck = ck ^ word;
         end
         // Pulled-down line outside the data phase
         dout <= (n > 3 + ABITS && n < 20 + ABITS) ?
            word[19 + ABITS - n] : 1'b0;
      end
   end
endmodule : srcl_rom_model

/* File: verif/tb.sv */
`timescale 1ns/10ps
module tb;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] aw_a = 8'h00;
   logic [7:0] ar_a = 8'h00;
   logic aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0, ar_v = 1'b0, r_r = 1'b0;
   logic [31:0] w_d = 32'h0, rdata;
   logic [2:0] sz = 3'h1;
   logic ai = 1'b0, hb = 1'b1, c_req = 1'b0, c_ack, c_rty;
   logic [3:0] c_idx = 4'h0;
   logic [15:0] c_dat;
   logic awrdy, wrdy, bv, arrdy, rv, sclk, cs, rdo, rdi, irq;
   logic [1:0] bresp, rresp;
   logic [33:0] exp_q[$];
   logic [33:0] e;
   logic [5:0] a6;
   int err_total = 0, check_count = 0, cyc = 0, seed = 32'h1354;
   srcl_top dut (.REF_CLK(clk), .RST_N(rst_n), .S_AXI_AWADDR(aw_a),
      .S_AXI_AWVALID(aw_v), .S_AXI_AWREADY(awrdy), .S_AXI_WDATA(w_d),
      .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(w_v), .S_AXI_WREADY(wrdy),
      .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(b_r),
      .S_AXI_ARADDR(ar_a), .S_AXI_ARVALID(ar_v), .S_AXI_ARREADY(arrdy),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv),
      .S_AXI_RREADY(r_r), .AUTOINIT_SELECT(ai), .ROM_SIZE_CODE(sz),
      .HOST_BUS_SELECT(hb), .SERIAL_ROM_CLOCK(sclk), .ROM_CS(cs),
      .ROM_DO(rdo), .ROM_DI(rdi), .HOST_CFG_REQ(c_req),
      .HOST_CFG_IDX(c_idx), .HOST_CFG_ACK(c_ack), .HOST_CFG_RETRY(c_rty),
      .HOST_CFG_DATA(c_dat), .PROC_IRQ(irq));
   srcl_rom_model #(.ABITS(6)) rom (.sclk(sclk), .cs(cs), .din(rdo),
      .dout(rdi));
   initial begin
      forever #2 clk = ~clk;
   end
   task automatic chk(input string nm, input logic [33:0] x,
      input logic [33:0] got);
      check_count++;
      if (got !== x) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", nm, x, got);
      end
   endtask : chk
   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : summarize
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] r);
      exp_q.push_back({r, 32'h0});
      @(posedge clk);
      aw_a <= a;
      w_d <= d;
      aw_v <= 1'b1;
      w_v <= 1'b1;
      b_r <= 1'b1;
      fork
         begin
            do @(negedge clk); while (!awrdy);
            @(posedge clk);
            aw_v <= 1'b0;
         end
         begin
            do @(negedge clk); while (!wrdy);
            @(posedge clk);
            w_v <= 1'b0;
         end
      join
      do @(negedge clk); while (!bv);
      @(posedge clk);
      b_r <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [33:0] x);
      exp_q.push_back(x);
      @(posedge clk);
      ar_a <= a;
      ar_v <= 1'b1;
      r_r <= 1'b1;
      do @(negedge clk); while (!arrdy);
      @(posedge clk);
      ar_v <= 1'b0;
      do @(negedge clk); while (!rv);
      @(posedge clk);
      r_r <= 1'b0;
   endtask : rd
   task automatic cfg(input logic [33:0] x);
      exp_q.push_back(x);
      @(posedge clk);
      c_req <= 1'b1;
      c_idx <= 4'($random(seed));
      @(posedge clk);
      c_req <= 1'b0;
      repeat (3) @(posedge clk);
   endtask : cfg
   always @(negedge clk) begin
      if (bv && b_r) begin
         e = exp_q.pop_front();
         chk("bresp", e, {bresp, 32'h0});
      end
      if (rv && r_r) begin
         e = exp_q.pop_front();
         chk("rdata", e, {rresp, rdata});
      end
      if (c_ack || c_rty) begin
         e = exp_q.pop_front();
         chk("cfg", e, {16'h0, c_ack, c_rty, c_dat});
      end
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 80000) begin
         err_total++;
         summarize();
      end
   end
   initial begin
      a6 = 6'($random(seed)) | 6'h10;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      cfg(34'h10000);
      repeat (10) @(posedge clk);
      rd(8'h08, {2'h0, 32'h10C});
      rd(8'h18, {2'h0, 32'h1});
      rd(8'h14, {2'h0, 32'h0});
      rd(8'h0C, {2'h0, 32'h1});
      cfg(34'h20000);
      $display("test defaults done");
      wr(8'h00, 32'hFFFFFFFF, 2'h0);
      rd(8'h00, {2'h0, 32'h3FF});
      wr(8'h04, $random(seed), 2'h0);
      rd(8'h04, {2'h0, 32'h0});
      wr(8'h1C, 32'h1, 2'h2);
      rd(8'h1C, {2'h2, 32'h0});
      $display("test registers done");
      wr(8'h10, 32'h1, 2'h0);
      repeat (3) @(negedge clk);
      chk("irq", 34'h1, {33'h0, irq});
      wr(8'h0C, 32'h1, 2'h0);
      repeat (3) @(negedge clk);
      chk("irq", 34'h0, {33'h0, irq});
      wr(8'h00, {26'h0, a6}, 2'h0);
      wr(8'h08, 32'h2, 2'h0);
      rd(8'h08, {2'h0, 32'h10A});
      do @(negedge clk); while (!irq);
      rd(8'h04, {18'h0, 16'hA500 ^ {7'h0, 3'b110, a6}});
      rd(8'h08, {2'h0, 32'h10E});
      $display("test read command done");
      rst_n <= 1'b0;
      ai <= 1'b1;
      hb <= 1'b0;
      sz <= 3'h4;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      cfg(34'h10000);
      repeat (10) @(posedge clk);
      rd(8'h08, {2'h0, 32'h164});
      rd(8'h14, {2'h0, 32'h0});
      rd(8'h18, {2'h0, 32'h1});
      $display("test strap reset done");
      summarize();
   end
endmodule : tb

/* File: verilog/srcl_cfg_mem.sv */
`timescale 1ns/10ps
module srcl_cfg_mem (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Write port
   input wire logic we,
   input wire logic [3:0] waddr,
   input wire logic [15:0] wdata,
   // Read port
   input wire logic [3:0] raddr,
   output logic [15:0] rdata
);
   logic [15:0] mem [0:12];

   always_ff @(posedge clk) begin
      if (we && waddr < 4'hD) begin
         mem[waddr] <= wdata;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= 16'h0000;
      end else begin
         rdata <= (raddr < 4'hD) ? mem[raddr] : 16'h0000;
      end
   end
endmodule : srcl_cfg_mem

/* File: verilog/srcl_consts.svh */
`ifndef SRCL_CONSTS_SVH
`define SRCL_CONSTS_SVH
// ==========================================
// Register byte offsets
`define SRCL_ADDR_OFS 8'h00
`define SRCL_DATA_OFS 8'h04
`define SRCL_CTRL_OFS 8'h08
`define SRCL_IRQ_STAT_OFS 8'h0C
`define SRCL_IRQ_EN_OFS 8'h10
`define SRCL_HOST_STAT_OFS 8'h14
`define SRCL_RST_STAT_OFS 8'h18
// ==========================================
// Field positions
`define SRCL_CTRL_RDY_BIT 2
`define SRCL_CTRL_SZ_LSB 3
`define SRCL_CTRL_AI_BIT 6
`define SRCL_CTRL_CERR_BIT 7
`define SRCL_CTRL_DONE_BIT 8
`define SRCL_IRQ_CMD_BIT 0
`define SRCL_IRQ_CERR_BIT 1
`define SRCL_HS_CERR_BIT 0
`define SRCL_HS_USED_BIT 1
`define SRCL_RS_DONE_BIT 0
`define SRCL_RS_CERR_BIT 1
// ==========================================
// Values and counts
`define SRCL_CK_SEED 16'hAAAA
`define SRCL_CK_IDX 4'hD
`define SRCL_CFG_DEFAULT 16'h0000
`define SRCL_ROM_CLK_DIV 2048
`define SRCL_HALF_CNT 10'(`SRCL_ROM_CLK_DIV / 2 - 1)
`define SRCL_STRAP_WAIT 2'h3
`define SRCL_RESP_OKAY 2'h0
`define SRCL_RESP_SLVERR 2'h2
`endif

/* File: verilog/srcl_pkg.sv */
package srcl_pkg;
   typedef enum logic [1:0] {
      SRCL_OP_SPECIAL = 2'h0,
      SRCL_OP_WRITE = 2'h1,
      SRCL_OP_READ = 2'h2,
      SRCL_OP_ERASE = 2'h3
   } srcl_op_e;
   typedef enum logic [3:0] {
      SRCL_LD_INIT = 4'h1,
      SRCL_LD_FETCH = 4'h2,
      SRCL_LD_WAIT = 4'h4,
      SRCL_LD_DONE = 4'h8
   } srcl_ld_e;
endpackage : srcl_pkg

/* File: verilog/srcl_rom_shift.sv */
`timescale 1ns/10ps
module srcl_rom_shift (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Half-period enable
   input wire logic tick,
   // Command
   input wire logic start,
   input wire logic [1:0] op,
   input wire logic [9:0] addr,
   input wire logic [3:0] abits,
   input wire logic [15:0] wdata,
   output logic busy,
   output logic done,
   output logic [15:0] rdata,
   // Serial pins
   input wire logic din,
   output logic sclk,
   output logic cs,
   output logic dout
);
   logic [28:0] frame;
   logic [28:0] frame_reg;
   logic [4:0] cnt_reg;
   logic [9:0] amask;

   assign amask = 10'((11'h001 << abits) - 11'h001);
   assign frame = (29'({1'b1, op}) << (5'(abits) + 5'h10))
      | (29'(addr & amask) << 16) | 29'(wdata);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         busy <= 1'b0;
         done <= 1'b0;
         cs <= 1'b0;
         sclk <= 1'b0;
         dout <= 1'b0;
         frame_reg <= 29'h0;
         cnt_reg <= 5'h00;
         rdata <= 16'h0000;
      end else begin
         done <= 1'b0;
         if (!busy && start) begin
            busy <= 1'b1;
            cs <= 1'b1;
            frame_reg <= frame;
            cnt_reg <= 5'(abits) + 5'h13;
            dout <= 1'b1;
         end else if (busy && tick) begin
            if (sclk) begin
               sclk <= 1'b0;
               dout <= (cnt_reg != 5'h00) ?
                  frame_reg[cnt_reg - 5'h01] : 1'b0;
               // Data bits arrive on the last sixteen clocks
               if (cnt_reg < 5'h10) begin
                  rdata <= {rdata[14:0], din};
               end
            end else if (cnt_reg != 5'h00) begin
               sclk <= 1'b1;
               cnt_reg <= cnt_reg - 5'h01;
            end else begin
               cs <= 1'b0;
               busy <= 1'b0;
               done <= 1'b1;
            end
         end
      end
   end
endmodule : srcl_rom_shift

/* File: verilog/srcl_top.sv */
// Added by the designer: the register addresses and the AXI4-Lite register port.
`timescale 1ns/10ps
`include "srcl_consts.svh"
module srcl_top (
   // Clock and reset
   input wire logic REF_CLK,
   input wire logic RST_N,
   // AXI4-Lite slave
   input wire logic [7:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [7:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   // Strap pins
   input wire logic AUTOINIT_SELECT,
   input wire logic [2:0] ROM_SIZE_CODE,
   input wire logic HOST_BUS_SELECT,
   // Serial ROM pins
   output logic SERIAL_ROM_CLOCK,
   output logic ROM_CS,
   output logic ROM_DO,
   input wire logic ROM_DI,
   // Host configuration read port
   input wire logic HOST_CFG_REQ,
   input wire logic [3:0] HOST_CFG_IDX,
   output logic HOST_CFG_ACK,
   output logic HOST_CFG_RETRY,
   output logic [15:0] HOST_CFG_DATA,
   // Processor interrupt
   output logic PROC_IRQ
);
   // ==========================================
   // Helpers
   function automatic logic [31:0] strb_merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] strb);
      logic [31:0] m;
      m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
      return (old & ~m) | (nw & m);
   endfunction : strb_merge

   function automatic logic [3:0] abits_of(input logic [2:0] sz);
      if (sz == 3'h1) return 4'h6;
      else if (sz == 3'h2) return 4'h7;
      else if (sz == 3'h4) return 4'hA;
      else return 4'h8;
   endfunction : abits_of

   // ==========================================
   // Pin synchronisers
   logic [4:0] pin_s1_reg;
   logic [4:0] pin_s2_reg;
   logic ai_s, hb_s, di_s;
   logic [2:0] sz_s;

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         pin_s1_reg <= 5'h00;
         pin_s2_reg <= 5'h00;
      end else begin
         pin_s1_reg <= {AUTOINIT_SELECT, ROM_SIZE_CODE, HOST_BUS_SELECT};
         pin_s2_reg <= pin_s1_reg;
      end
   end

   logic di_s1_reg, di_s2_reg;
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         di_s1_reg <= 1'b0;
         di_s2_reg <= 1'b0;
      end else begin
         di_s1_reg <= ROM_DI;
         di_s2_reg <= di_s1_reg;
      end
   end
   assign ai_s = pin_s2_reg[4];
   assign sz_s = pin_s2_reg[3:1];
   assign hb_s = pin_s2_reg[0];
   assign di_s = di_s2_reg;

   // ==========================================
   // Serial clock divider
   logic [9:0] div_reg;
   logic tick;
   assign tick = (div_reg == `SRCL_HALF_CNT);
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) div_reg <= 10'h000;
      else div_reg <= tick ? 10'h000 : div_reg + 10'h001;
   end

   // ==========================================
   // State
   srcl_pkg::srcl_ld_e st_reg;
   logic [1:0] init_cnt_reg;
   logic [3:0] idx_reg;
   logic [15:0] xor_reg;
   logic ai_reg, cfg_done_reg, cerr_reg, used_reg, use_def_reg;
   logic [2:0] size_reg;
   logic [9:0] addr_reg;
   logic [15:0] tx_reg, data_reg;
   logic [1:0] op_reg;
   logic pend_reg, cmd_act_reg, ready_reg;
   logic irq_cmd_reg, irq_cerr_reg;
   logic [1:0] irq_en_reg;
   logic eng_busy, eng_done;
   logic [15:0] eng_rdata;
   logic [15:0] mem_q;

   // ==========================================
   // AXI4-Lite handshakes
   logic aw_have_reg, w_have_reg;
   logic [7:0] aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;
   logic aw_fire, w_fire, ar_fire, wr_go;
   logic [7:0] wa;
   logic sel_addr, sel_data, sel_ctrl, sel_ist, sel_ien, wr_ok;
   logic [31:0] wm;

   assign aw_fire = S_AXI_AWVALID & S_AXI_AWREADY;
   assign w_fire = S_AXI_WVALID & S_AXI_WREADY;
   assign ar_fire = S_AXI_ARVALID & S_AXI_ARREADY;
   assign wr_go = aw_have_reg & w_have_reg & ~S_AXI_BVALID;
   assign wa = {aw_addr_reg[7:2], 2'h0};
   assign sel_addr = wr_go & (wa == `SRCL_ADDR_OFS);
   assign sel_data = wr_go & (wa == `SRCL_DATA_OFS);
   assign sel_ctrl = wr_go & (wa == `SRCL_CTRL_OFS);
   assign sel_ist = wr_go & (wa == `SRCL_IRQ_STAT_OFS);
   assign sel_ien = wr_go & (wa == `SRCL_IRQ_EN_OFS);
   assign wr_ok = sel_addr | sel_data | sel_ctrl | sel_ist | sel_ien
      | (wa == `SRCL_HOST_STAT_OFS) | (wa == `SRCL_RST_STAT_OFS);
   assign wm = strb_merge(32'h0, w_data_reg, w_strb_reg);

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         S_AXI_AWREADY <= 1'b0;
         S_AXI_WREADY <= 1'b0;
         S_AXI_BVALID <= 1'b0;
         S_AXI_BRESP <= `SRCL_RESP_OKAY;
         aw_have_reg <= 1'b0;
         w_have_reg <= 1'b0;
         aw_addr_reg <= 8'h00;
         w_data_reg <= 32'h0;
         w_strb_reg <= 4'h0;
      end else begin
         S_AXI_AWREADY <= ~aw_fire & ~aw_have_reg & ~S_AXI_BVALID;
         S_AXI_WREADY <= ~w_fire & ~w_have_reg & ~S_AXI_BVALID;
         if (aw_fire) begin
            aw_have_reg <= 1'b1;
            aw_addr_reg <= S_AXI_AWADDR;
         end
         if (w_fire) begin
            w_have_reg <= 1'b1;
            w_data_reg <= S_AXI_WDATA;
            w_strb_reg <= S_AXI_WSTRB;
         end
         if (wr_go) begin
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP <= wr_ok ? `SRCL_RESP_OKAY : `SRCL_RESP_SLVERR;
         end else if (S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
         end
      end
   end

   // ==========================================
   // Read data mux
   logic [7:0] ra;
   logic [31:0] rd_val;
   logic rd_ok;
   assign ra = {S_AXI_ARADDR[7:2], 2'h0};

   always_comb begin
      rd_val = 32'h0;
      rd_ok = 1'b1;
      if (ra == `SRCL_ADDR_OFS) begin
         rd_val = {22'h0, addr_reg};
      end else if (ra == `SRCL_DATA_OFS) begin
         rd_val = {16'h0, data_reg};
      end else if (ra == `SRCL_CTRL_OFS) begin
         rd_val[1:0] = op_reg;
         rd_val[`SRCL_CTRL_RDY_BIT] = ready_reg;
         rd_val[`SRCL_CTRL_SZ_LSB +: 3] = size_reg;
         rd_val[`SRCL_CTRL_AI_BIT] = ai_reg;
         rd_val[`SRCL_CTRL_CERR_BIT] = cerr_reg;
         rd_val[`SRCL_CTRL_DONE_BIT] = cfg_done_reg;
      end else if (ra == `SRCL_IRQ_STAT_OFS) begin
         rd_val[`SRCL_IRQ_CMD_BIT] = irq_cmd_reg;
         rd_val[`SRCL_IRQ_CERR_BIT] = irq_cerr_reg;
      end else if (ra == `SRCL_IRQ_EN_OFS) begin
         rd_val[1:0] = irq_en_reg;
      end else if (ra == `SRCL_HOST_STAT_OFS) begin
         rd_val[`SRCL_HS_CERR_BIT] = cerr_reg;
         rd_val[`SRCL_HS_USED_BIT] = used_reg;
      end else if (ra == `SRCL_RST_STAT_OFS) begin
         rd_val[`SRCL_RS_DONE_BIT] = cfg_done_reg;
         rd_val[`SRCL_RS_CERR_BIT] = cerr_reg & use_def_reg;
      end else begin
         rd_ok = 1'b0;
      end
   end

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         S_AXI_ARREADY <= 1'b0;
         S_AXI_RVALID <= 1'b0;
         S_AXI_RDATA <= 32'h0;
         S_AXI_RRESP <= `SRCL_RESP_OKAY;
      end else begin
         S_AXI_ARREADY <= ~ar_fire & ~S_AXI_RVALID;
         if (ar_fire) begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RDATA <= rd_val;
            S_AXI_RRESP <= rd_ok ? `SRCL_RESP_OKAY : `SRCL_RESP_SLVERR;
         end else if (S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
         end
      end
   end

   // ==========================================
   // Loader and command arbitration
   logic auto_go, ld_start, cmd_go, op_wr, ld_last, ld_fail, ld_finish;
   logic cmd_done, wr_type, eng_start;
   logic [1:0] eng_op;
   logic [9:0] eng_addr;
   logic [15:0] eng_wdata;
   logic [3:0] abits;
   logic [1:0] top2;

   assign auto_go = ai_s & (sz_s != 3'h0) & hb_s;
   assign ld_start = (st_reg == srcl_pkg::SRCL_LD_FETCH) & ~eng_busy;
   assign ld_last = (st_reg == srcl_pkg::SRCL_LD_WAIT) & eng_done
      & (idx_reg == `SRCL_CK_IDX);
   // seeded xor compared with stored checksum
   assign ld_fail = ld_last & (xor_reg != eng_rdata);
   assign ld_finish = ld_last | ((st_reg == srcl_pkg::SRCL_LD_INIT)
      & (init_cnt_reg == `SRCL_STRAP_WAIT) & ~auto_go);
   // opcode byte write starts a command
   assign op_wr = sel_ctrl & w_strb_reg[0];
   // queued opcode waits for idle engine
   assign cmd_go = cfg_done_reg & pend_reg & ~eng_busy & ~cmd_act_reg;
   assign cmd_done = cmd_act_reg & eng_done;
   assign abits = abits_of(size_reg);
   assign top2 = 2'(addr_reg >> (abits - 4'h2));
   // only write and write-all carry data
   assign wr_type = (op_reg == srcl_pkg::SRCL_OP_WRITE)
      | ((op_reg == srcl_pkg::SRCL_OP_SPECIAL) & (top2 == 2'h1));
   assign eng_start = ld_start | cmd_go;
   assign eng_op = ld_start ? srcl_pkg::SRCL_OP_READ : op_reg;
   assign eng_addr = ld_start ? {6'h00, idx_reg} : addr_reg;
   assign eng_wdata = (!ld_start && wr_type) ? tx_reg : 16'h0000;

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         st_reg <= srcl_pkg::SRCL_LD_INIT;
         init_cnt_reg <= 2'h0;
         idx_reg <= 4'h0;
         xor_reg <= `SRCL_CK_SEED;
         ai_reg <= 1'b0;
         size_reg <= 3'h0;
         used_reg <= 1'b0;
         use_def_reg <= 1'b0;
         cerr_reg <= 1'b0;
         cfg_done_reg <= 1'b0;
      end else begin
         case (st_reg)
            srcl_pkg::SRCL_LD_INIT: begin
               init_cnt_reg <= init_cnt_reg + 2'h1;
               if (init_cnt_reg == `SRCL_STRAP_WAIT) begin
                  ai_reg <= ai_s;
                  size_reg <= sz_s;
                  if (auto_go) begin
                     used_reg <= 1'b1;
                     st_reg <= srcl_pkg::SRCL_LD_FETCH;
                  end else begin
                     use_def_reg <= 1'b1;
                     cfg_done_reg <= 1'b1;
                     st_reg <= srcl_pkg::SRCL_LD_DONE;
                  end
               end
            end
            srcl_pkg::SRCL_LD_FETCH: begin
               if (ld_start) st_reg <= srcl_pkg::SRCL_LD_WAIT;
            end
            srcl_pkg::SRCL_LD_WAIT: begin
               if (ld_last) begin
                  cerr_reg <= ld_fail;
                  use_def_reg <= ld_fail;
                  cfg_done_reg <= 1'b1;
                  st_reg <= srcl_pkg::SRCL_LD_DONE;
               end else if (eng_done) begin
                  xor_reg <= xor_reg ^ eng_rdata;
                  idx_reg <= idx_reg + 4'h1;
                  st_reg <= srcl_pkg::SRCL_LD_FETCH;
               end
            end
            default: st_reg <= srcl_pkg::SRCL_LD_DONE;
         endcase
      end
   end

   // ==========================================
   // Command registers
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         addr_reg <= 10'h000;
         tx_reg <= 16'h0000;
         data_reg <= 16'h0000;
         op_reg <= 2'h0;
         pend_reg <= 1'b0;
         cmd_act_reg <= 1'b0;
         ready_reg <= 1'b0;
         irq_en_reg <= 2'h0;
      end else begin
         if (sel_addr) addr_reg <= wm[9:0] | (addr_reg & ~10'(
            strb_merge(32'h0, 32'hFFFFFFFF, w_strb_reg)));
         // write lands in hidden shift word
         if (sel_data) tx_reg <= 16'(strb_merge({16'h0, tx_reg},
            w_data_reg, w_strb_reg));
         if (sel_ien) irq_en_reg <= 2'(strb_merge({30'h0, irq_en_reg},
            w_data_reg, w_strb_reg));
         if (op_wr) op_reg <= w_data_reg[1:0];
         if (op_wr) pend_reg <= 1'b1;
         else if (cmd_go) pend_reg <= 1'b0;
         if (cmd_go) cmd_act_reg <= 1'b1;
         else if (eng_done) cmd_act_reg <= 1'b0;
         if (cmd_done && op_reg == srcl_pkg::SRCL_OP_READ) begin
            data_reg <= eng_rdata;
         end
         if (op_wr) ready_reg <= 1'b0;
         else if (ld_finish | (cmd_done & ~pend_reg)) ready_reg <= 1'b1;
      end
   end

   // ==========================================
   // Interrupt flags, set beats clear
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         irq_cmd_reg <= 1'b0;
         irq_cerr_reg <= 1'b0;
         PROC_IRQ <= 1'b0;
      end else begin
         if (cmd_done | ld_finish) irq_cmd_reg <= 1'b1;
         else if (sel_ist & w_data_reg[`SRCL_IRQ_CMD_BIT]) begin
            irq_cmd_reg <= 1'b0;
         end
         if (ld_fail) irq_cerr_reg <= 1'b1;
         else if (sel_ist & w_data_reg[`SRCL_IRQ_CERR_BIT]) begin
            irq_cerr_reg <= 1'b0;
         end
         PROC_IRQ <= |({irq_cerr_reg, irq_cmd_reg} & irq_en_reg);
      end
   end

   // ==========================================
   // Host configuration port
   logic cfg_rd_reg;
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         cfg_rd_reg <= 1'b0;
         HOST_CFG_ACK <= 1'b0;
         HOST_CFG_RETRY <= 1'b0;
         HOST_CFG_DATA <= 16'h0000;
      end else begin
         cfg_rd_reg <= HOST_CFG_REQ & cfg_done_reg;
         HOST_CFG_RETRY <= HOST_CFG_REQ & ~cfg_done_reg;
         HOST_CFG_ACK <= cfg_rd_reg;
         if (cfg_rd_reg) begin
            HOST_CFG_DATA <= use_def_reg ? `SRCL_CFG_DEFAULT : mem_q;
         end
      end
   end

   // ==========================================
   // Submodules
   // words 0h to Ch stored by index
   srcl_cfg_mem u_mem (
      .clk(REF_CLK),
      .rst_n(RST_N),
      .we((st_reg == srcl_pkg::SRCL_LD_WAIT) & eng_done),
      .waddr(idx_reg),
      .wdata(eng_rdata),
      .raddr(HOST_CFG_IDX),
      .rdata(mem_q)
   );

   srcl_rom_shift u_shift (
      .clk(REF_CLK),
      .rst_n(RST_N),
      .tick(tick),
      .start(eng_start),
      .op(eng_op),
      .addr(eng_addr),
      .abits(abits_of(ld_start ? sz_s : size_reg)),
      .wdata(eng_wdata),
      .busy(eng_busy),
      .done(eng_done),
      .rdata(eng_rdata),
      .din(di_s),
      .sclk(SERIAL_ROM_CLOCK),
      .cs(ROM_CS),
      .dout(ROM_DO)
   );

   // ==========================================
   // Checks
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!RST_N);

   a_ready_on_op:
      assert property (op_wr |=> !ready_reg)
      else $error("ready not cleared by opcode write");
   a_cfg_retry:
      assert property (HOST_CFG_REQ && !cfg_done_reg |=> HOST_CFG_RETRY)
      else $error("config read not retried");
   a_no_rom_default:
      assert property (!used_reg && !cmd_act_reg |-> !ROM_CS)
      else $error("serial ROM touched without autoload");
   a_cerr_default:
      assert property (cerr_reg |-> use_def_reg)
      else $error("checksum error without defaults");
   a_cerr_flags:
      assert property (ld_fail |=> irq_cerr_reg && cerr_reg)
      else $error("checksum error flags not set");
   a_cmd_irq:
      assert property (cmd_done |=> irq_cmd_reg)
      else $error("completion flag not set");
   a_clk_idle:
      assert property (!ROM_CS |-> !SERIAL_ROM_CLOCK)
      else $error("serial clock runs outside access");
   a_size_hold:
      assert property (cfg_done_reg |=> $stable(size_reg))
      else $error("size code changed after capture");
   a_done_ready:
      assert property ($rose(cfg_done_reg) |-> ready_reg || pend_reg)
      else $error("ready not set with configuration done");
endmodule : srcl_top
